// [rtl/stn_pkg.sv]
// constants, field layout and carrier types of the self-test / nvm / interface register bank
// assumes a 100 MHz system clock and a host reaching the bank over the serial port
package stn_pkg;

    // register addresses as seen on the serial link (7-bit address byte)
    localparam logic [6:0] ADDR_SELF_TEST = 7'h32;
    localparam logic [6:0] ADDR_NVM_CTRL = 7'h33;
    localparam logic [6:0] ADDR_IF_CFG = 7'h34;

    // self_test_config fields
    localparam int ST_AXIS_LSB = 0;
    localparam int ST_SIGN_POS = 2;
    localparam int ST_AMP_POS = 4;
    localparam logic [7:0] ST_RESET = 8'h00;

    // nvm_control fields
    localparam int NVM_MODE_POS = 0;
    localparam int NVM_TRIG_POS = 1;
    localparam int NVM_RDY_POS = 2;
    localparam int NVM_LOAD_POS = 3;
    localparam int NVM_REMAIN_LSB = 4;
    // remaining-write count has no reset value of its own; plain full count
    localparam logic [3:0] NVM_REMAIN_RESET = 4'hF;

    // interface_config fields
    localparam int IF_3W_POS = 0;
    localparam int IF_WDT_SEL_POS = 1;
    localparam int IF_WDT_EN_POS = 2;
    localparam logic [7:0] IF_RESET = 8'h00;

    // serial frame: first byte is read flag and address
    localparam int SPI_RD_POS = 7;

    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int WDT_SHORT_US = 1000;
    localparam int WDT_LONG_US = 50_000;
    localparam int WDT_SHORT_CYC = WDT_SHORT_US * (CLK_HZ / 1_000_000);
    localparam int WDT_LONG_CYC = WDT_LONG_US * (CLK_HZ / 1_000_000);
    localparam int WDT_CNT_W = 23;

    typedef enum logic [1:0]
    {
        AXIS_OFF = 2'h0,
        AXIS_X = 2'h1,
        AXIS_Y = 2'h2,
        AXIS_Z = 2'h3
    } stn_axis_t;

    typedef enum logic [2:0]
    {
        NVM_IDLE = 3'h1,
        NVM_LOAD = 3'h2,
        NVM_PROG = 3'h4
    } stn_nvm_state_t;

    // write carried from the link domain to the system domain
    typedef struct packed
    {
        logic [6:0] addr;
        logic [7:0] data;
    } stn_wr_req_t;

    // frozen read image handed to the link domain
    typedef struct packed
    {
        logic [7:0] self_test;
        logic [7:0] nvm_ctrl;
        logic [7:0] if_cfg;
    } stn_rd_image_t;

endpackage : stn_pkg

// [rtl/stn_sync.sv]
// two-flop level synchroniser, one per bit
// assumes inputs are levels, slow against the receiving clock
`timescale 1ns/100ps
module stn_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("stn_sync: WIDTH must be at least 1");
    end

    // first stage is read by the second stage only
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_r <= RESET_VAL;
            sync_o <= RESET_VAL;
        end
        else
        begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule : stn_sync

// [rtl/stn_regs.sv]
// register bank for self-test, nvm control and interface options, with its serial port
// assumes spi_sck_i idles between frames, spi mode 3 (sample on rising edge)
`timescale 1ns/100ps
module stn_regs #(
    parameter int WDT_SHORT_CYC = stn_pkg::WDT_SHORT_CYC,
    parameter int WDT_LONG_CYC = stn_pkg::WDT_LONG_CYC
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic spi_sck_i,
    input wire logic spi_cs_n_i,
    input wire logic serial_data_in_pin_i,
    output logic serial_data_in_pin_o,
    output logic serial_data_in_pin_oe_n_o,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_n_o,
    input wire logic i2c_mode_i,
    output logic i2c_if_reset_o,
    input wire logic nvm_done_i,
    output logic nvm_load_req_o,
    output logic nvm_prog_req_o,
    output logic self_test_x_o,
    output logic self_test_y_o,
    output logic self_test_z_o,
    output logic self_test_sign_o,
    output logic self_test_amp_o,
    output logic three_wire_select_o
);

    localparam logic [stn_pkg::WDT_CNT_W-1:0] SHORT_LIM = WDT_SHORT_CYC[stn_pkg::WDT_CNT_W-1:0];
    localparam logic [stn_pkg::WDT_CNT_W-1:0] LONG_LIM = WDT_LONG_CYC[stn_pkg::WDT_CNT_W-1:0];

    if (WDT_SHORT_CYC < 1 || WDT_LONG_CYC < 1 ||
        WDT_SHORT_CYC >= (1 << stn_pkg::WDT_CNT_W) || WDT_LONG_CYC >= (1 << stn_pkg::WDT_CNT_W))
    begin : g_bad_wdt
        $error("stn_regs: watchdog counts out of range");
    end

    // ---------------------------------------------------------------
    // link domain (spi_sck_i), held in reset while chip select is high, apart from the write toggle and payload
    // ---------------------------------------------------------------
    logic link_rst;
    logic [2:0] bit_cnt_r;
    logic [6:0] in_sr_r;
    logic hdr_done_r;
    logic rd_r;
    logic [6:0] addr_r;
    logic wr_tgl_r;
    stn_pkg::stn_wr_req_t wr_req_r;
    logic [7:0] out_sr_r;
    logic out_r;
    logic sdo_oe_n_r;
    logic pin_oe_n_r;
    logic link_3w;
    logic [7:0] rx_byte;
    logic [7:0] rd_byte;
    stn_pkg::stn_rd_image_t rd_image_r;

    assign link_rst = rst_i | spi_cs_n_i;
    assign rx_byte = {in_sr_r, serial_data_in_pin_i};

    // image is frozen for the whole frame, so reading it here is safe
    always_comb
    begin
        case (addr_r)
            stn_pkg::ADDR_SELF_TEST: rd_byte = rd_image_r.self_test;
            stn_pkg::ADDR_NVM_CTRL: rd_byte = rd_image_r.nvm_ctrl;
            stn_pkg::ADDR_IF_CFG: rd_byte = rd_image_r.if_cfg;
            default: rd_byte = 8'h00;
        endcase
    end

    stn_sync #(
        .WIDTH(1),
        .RESET_VAL(1'b0)
    ) u_sync_3w (
        .clock_i(spi_sck_i),
        .rst_i(link_rst),
        .async_i(three_wire_select_o),
        .sync_o(link_3w)
    );

    always_ff @(posedge spi_sck_i or posedge link_rst)
    begin
        if (link_rst)
        begin
            bit_cnt_r <= 3'h0;
            in_sr_r <= 7'h00;
            hdr_done_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= 7'h00;
        end
        else
        begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            in_sr_r <= rx_byte[6:0];
            if (bit_cnt_r == 3'h7)
            begin
                if (!hdr_done_r)
                begin
                    hdr_done_r <= 1'b1;
                    rd_r <= rx_byte[stn_pkg::SPI_RD_POS];
                    addr_r <= rx_byte[6:0];
                end
                else
                begin
                    // burst access walks to the next address
                    addr_r <= addr_r + 7'h01;
                end
            end
        end
    end

    // toggle and payload survive chip select so the system side can catch them
    always_ff @(posedge spi_sck_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_tgl_r <= 1'b0;
            wr_req_r <= '0;
        end
        else if (!spi_cs_n_i && bit_cnt_r == 3'h7 && hdr_done_r && !rd_r)
        begin
            wr_req_r.addr <= addr_r;
            wr_req_r.data <= rx_byte;
            wr_tgl_r <= ~wr_tgl_r;
        end
    end

    // read data leaves on the falling edge, half a bit ahead of the host sample
    always_ff @(negedge spi_sck_i or posedge link_rst)
    begin
        if (link_rst)
        begin
            out_sr_r <= 8'h00;
            out_r <= 1'b0;
            sdo_oe_n_r <= 1'b1;
            pin_oe_n_r <= 1'b1;
        end
        else
        begin
            // enables are flops of their own so the pins see no decode glitch
            sdo_oe_n_r <= ~(hdr_done_r & rd_r & ~link_3w);
            pin_oe_n_r <= ~(hdr_done_r & rd_r & link_3w);
            if (hdr_done_r && rd_r)
            begin
                if (bit_cnt_r == 3'h0)
                begin
                    out_r <= rd_byte[7];
                    out_sr_r <= {rd_byte[6:0], 1'b0};
                end
                else
                begin
                    out_r <= out_sr_r[7];
                    out_sr_r <= {out_sr_r[6:0], 1'b0};
                end
            end
        end
    end

    assign spi_sdo_o = out_r;
    assign serial_data_in_pin_o = out_r;
    assign spi_sdo_oe_n_o = sdo_oe_n_r;
    assign serial_data_in_pin_oe_n_o = pin_oe_n_r;

    // ---------------------------------------------------------------
    // system domain (clock_i)
    // ---------------------------------------------------------------
    logic cs_n_s;
    logic wr_tgl_s;
    logic sda_s;
    logic i2c_mode_s;
    logic wr_seen_r;
    logic wr_stb;
    logic [7:0] st_cfg_r;
    logic [7:0] if_cfg_r;
    logic prog_mode_r;
    logic [3:0] remain_r;
    stn_pkg::stn_nvm_state_t nvm_state_r;
    logic [stn_pkg::WDT_CNT_W-1:0] wdt_cnt_r;
    logic [stn_pkg::WDT_CNT_W-1:0] wdt_lim;
    logic wdt_armed;
    logic nvm_wr;
    logic [7:0] nvm_rd;
    stn_pkg::stn_axis_t axis;

    stn_sync #(
        .WIDTH(4),
        .RESET_VAL(4'b1100)
    ) u_sync_sys (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({spi_cs_n_i, serial_data_in_pin_i, wr_tgl_r, i2c_mode_i}),
        .sync_o({cs_n_s, sda_s, wr_tgl_s, i2c_mode_s})
    );

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_seen_r <= 1'b0;
        end
        else
        begin
            wr_seen_r <= wr_tgl_s;
        end
    end

    // payload has been stable since before the toggle moved
    assign wr_stb = wr_tgl_s ^ wr_seen_r;
    assign nvm_wr = wr_stb && wr_req_r.addr == stn_pkg::ADDR_NVM_CTRL;

    // reserved bits are dropped on write and read back as zero
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_cfg_r <= stn_pkg::ST_RESET;
        end
        else if (wr_stb && wr_req_r.addr == stn_pkg::ADDR_SELF_TEST)
        begin
            st_cfg_r <= wr_req_r.data & 8'h17;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            if_cfg_r <= stn_pkg::IF_RESET;
        end
        else if (wr_stb && wr_req_r.addr == stn_pkg::ADDR_IF_CFG)
        begin
            if_cfg_r <= wr_req_r.data & 8'h07;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prog_mode_r <= 1'b0;
        end
        else if (nvm_wr)
        begin
            prog_mode_r <= wr_req_r.data[stn_pkg::NVM_MODE_POS];
        end
    end

    // nvm sequencer: one job at a time, finished by nvm_done_i
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            nvm_state_r <= stn_pkg::NVM_IDLE;
            remain_r <= stn_pkg::NVM_REMAIN_RESET;
            nvm_load_req_o <= 1'b0;
            nvm_prog_req_o <= 1'b0;
        end
        else
        begin
            nvm_load_req_o <= 1'b0;
            nvm_prog_req_o <= 1'b0;
            case (nvm_state_r)
                stn_pkg::NVM_IDLE:
                begin
                    // triggers while busy are dropped; load wins if both are set
                    if (nvm_wr && wr_req_r.data[stn_pkg::NVM_LOAD_POS])
                    begin
                        nvm_state_r <= stn_pkg::NVM_LOAD;
                        nvm_load_req_o <= 1'b1;
                    end
                    else if (nvm_wr && wr_req_r.data[stn_pkg::NVM_TRIG_POS] &&
                             prog_mode_r && remain_r != 4'h0)
                    begin
                        nvm_state_r <= stn_pkg::NVM_PROG;
                        nvm_prog_req_o <= 1'b1;
                        remain_r <= remain_r - 4'h1;
                    end
                end
                stn_pkg::NVM_LOAD,
                stn_pkg::NVM_PROG:
                begin
                    if (nvm_done_i)
                    begin
                        nvm_state_r <= stn_pkg::NVM_IDLE;
                    end
                end
                default:
                begin
                    nvm_state_r <= stn_pkg::NVM_IDLE;
                end
            endcase
        end
    end

    // trigger bit always reads 0; load bit reads 1 until its update ends
    always_comb
    begin
        nvm_rd = 8'h00;
        nvm_rd[stn_pkg::NVM_REMAIN_LSB +: 4] = remain_r;
        nvm_rd[stn_pkg::NVM_LOAD_POS] = nvm_state_r == stn_pkg::NVM_LOAD;
        nvm_rd[stn_pkg::NVM_RDY_POS] = nvm_state_r == stn_pkg::NVM_IDLE;
        nvm_rd[stn_pkg::NVM_TRIG_POS] = 1'b0;
        nvm_rd[stn_pkg::NVM_MODE_POS] = prog_mode_r;
    end

    // image refreshed only between frames; status seen mid-frame is the frame-start value
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rd_image_r <= '0;
        end
        else if (cs_n_s)
        begin
            rd_image_r.self_test <= st_cfg_r;
            rd_image_r.nvm_ctrl <= nvm_rd;
            rd_image_r.if_cfg <= if_cfg_r;
        end
    end

    // self-test drive, decoded once here for the analog front end
    assign axis = stn_pkg::stn_axis_t'(st_cfg_r[stn_pkg::ST_AXIS_LSB +: 2]);

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            self_test_x_o <= 1'b0;
            self_test_y_o <= 1'b0;
            self_test_z_o <= 1'b0;
            self_test_sign_o <= 1'b0;
            self_test_amp_o <= 1'b0;
        end
        else
        begin
            self_test_x_o <= axis == stn_pkg::AXIS_X;
            self_test_y_o <= axis == stn_pkg::AXIS_Y;
            self_test_z_o <= axis == stn_pkg::AXIS_Z;
            self_test_sign_o <= st_cfg_r[stn_pkg::ST_SIGN_POS];
            self_test_amp_o <= st_cfg_r[stn_pkg::ST_AMP_POS];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            three_wire_select_o <= 1'b0;
        end
        else
        begin
            three_wire_select_o <= if_cfg_r[stn_pkg::IF_3W_POS];
        end
    end

    // data-line watchdog
    assign wdt_armed = if_cfg_r[stn_pkg::IF_WDT_EN_POS] & i2c_mode_s;
    assign wdt_lim = if_cfg_r[stn_pkg::IF_WDT_SEL_POS] ? LONG_LIM : SHORT_LIM;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wdt_cnt_r <= '0;
            i2c_if_reset_o <= 1'b0;
        end
        else
        begin
            i2c_if_reset_o <= 1'b0;
            if (!wdt_armed || sda_s)
            begin
                wdt_cnt_r <= '0;
            end
            else if (wdt_cnt_r >= wdt_lim - 1'b1)
            begin
                // fires once, then restarts timing of a still-low line
                wdt_cnt_r <= '0;
                i2c_if_reset_o <= 1'b1;
            end
            else
            begin
                wdt_cnt_r <= wdt_cnt_r + 1'b1;
            end
        end
    end

endmodule : stn_regs

// [testbench/stn_regs_props.sv]
// assertions on the register bank ports: triggers, decode, watchdog, pin enables
// assumes it is bound to stn_regs and samples everything on the system clock
`timescale 1ns/100ps
module stn_regs_props #(
    parameter int WDT_SHORT_CYC = 20,
    parameter int WDT_LONG_CYC = 50
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic spi_cs_n_i,
    input wire logic serial_data_in_pin_i,
    input wire logic serial_data_in_pin_oe_n_o,
    input wire logic spi_sdo_oe_n_o,
    input wire logic i2c_mode_i,
    input wire logic i2c_if_reset_o,
    input wire logic nvm_done_i,
    input wire logic nvm_load_req_o,
    input wire logic nvm_prog_req_o,
    input wire logic self_test_x_o,
    input wire logic self_test_y_o,
    input wire logic self_test_z_o,
    input wire logic three_wire_select_o
);
    int lo_cnt;
    logic busy_r;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // raw low run; the design sees the pin two flops later, so it can only lag this
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            lo_cnt <= 0;
        else
            lo_cnt <= serial_data_in_pin_i ? 0 : lo_cnt + 1;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            busy_r <= 1'b0;
        else if (nvm_load_req_o || nvm_prog_req_o)
            busy_r <= 1'b1;
        else if (nvm_done_i)
            busy_r <= 1'b0;
    end

    sequence s_quiet(x);
        ##1 (!x) [*3];
    endsequence

    property p_axis;
        $onehot0({self_test_x_o, self_test_y_o, self_test_z_o});
    endproperty
    a_axis: assert property (p_axis) else $error("axis outputs not one-hot");

    property p_load_pulse;
        nvm_load_req_o |-> s_quiet(nvm_load_req_o);
    endproperty
    a_load_pulse: assert property (p_load_pulse) else $error("load request too long");

    property p_prog_pulse;
        nvm_prog_req_o |-> s_quiet(nvm_prog_req_o);
    endproperty
    a_prog_pulse: assert property (p_prog_pulse) else $error("program request too long");

    property p_busy;
        (nvm_load_req_o || nvm_prog_req_o) |-> !busy_r;
    endproperty
    a_busy: assert property (p_busy) else $error("trigger taken while busy");

    property p_wdt_min;
        i2c_if_reset_o |-> lo_cnt >= WDT_SHORT_CYC;
    endproperty
    a_wdt_min: assert property (p_wdt_min) else $error("watchdog fired early");

    // two sync flops plus the counter stage: the pulse reflects pin and mode three edges back
    property p_wdt_mode;
        i2c_if_reset_o |-> $past(i2c_mode_i, 3) && !$past(serial_data_in_pin_i, 3);
    endproperty
    a_wdt_mode: assert property (p_wdt_mode) else $error("watchdog outside i2c mode");

    property p_wdt_pulse;
        i2c_if_reset_o |-> s_quiet(i2c_if_reset_o);
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog reset too long");

    property p_oe_3w;
        !serial_data_in_pin_oe_n_o |-> !spi_cs_n_i && three_wire_select_o && spi_sdo_oe_n_o;
    endproperty
    a_oe_3w: assert property (p_oe_3w) else $error("data pin driven outside 3-wire read");

    property p_oe_4w;
        !spi_sdo_oe_n_o |-> !spi_cs_n_i && !three_wire_select_o;
    endproperty
    a_oe_4w: assert property (p_oe_4w) else $error("sdo driven outside 4-wire read");
endmodule : stn_regs_props

bind stn_regs stn_regs_props #(.WDT_SHORT_CYC(WDT_SHORT_CYC), .WDT_LONG_CYC(WDT_LONG_CYC)) u_props (
    .clock_i(clock_i), .rst_i(rst_i), .spi_cs_n_i(spi_cs_n_i),
    .serial_data_in_pin_i(serial_data_in_pin_i),
    .serial_data_in_pin_oe_n_o(serial_data_in_pin_oe_n_o), .spi_sdo_oe_n_o(spi_sdo_oe_n_o),
    .i2c_mode_i(i2c_mode_i), .i2c_if_reset_o(i2c_if_reset_o), .nvm_done_i(nvm_done_i),
    .nvm_load_req_o(nvm_load_req_o), .nvm_prog_req_o(nvm_prog_req_o),
    .self_test_x_o(self_test_x_o), .self_test_y_o(self_test_y_o),
    .self_test_z_o(self_test_z_o), .three_wire_select_o(three_wire_select_o));

// [testbench/stn_host_model.sv]
// host-side serial master for the register bank, spi mode 3, 48 ns link period
// assumes the bench tells it whether reads come on the shared data pin
`timescale 1ns/100ps
module stn_host_model (
    output logic sck_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic sdo_i,
    input wire logic pin_i,
    input wire logic three_wire_i
);
    initial
    begin
        sck_o = 1'b1;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // link clock stands high between frames
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdat,
                        output logic [7:0] rdat);
        logic [15:0] sh;
        sh = {rd, addr, wdat};
        rdat = 8'h00;
        cs_n_o = 1'b0;
        #24;
        for (int i = 15; i >= 0; i--)
        begin
            sck_o = 1'b0;
            // toggled in the read phase: an undriven line shows no stale level
            mosi_o = (rd && i < 8) ? ~mosi_o : sh[i];
            #24;
            sck_o = 1'b1;
            if (rd && i < 8)
                rdat[i] = three_wire_i ? pin_i : sdo_i;
            #24;
        end
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        // ten system cycles: the write lands and the frame gap is kept
        #100;
    endtask : xfer
endmodule : stn_host_model

// [testbench/selftest_nvm_iface_regs_bench.sv]
// self-checking bench for stn_regs driven through the host serial model
// assumes shortened watchdog counts; the bench plays the nvm controller
`timescale 1ns/100ps
module selftest_nvm_iface_regs_bench;
    localparam int SHORT = 20;
    localparam int LONG = 50;
    localparam logic [6:0] NVM = stn_pkg::ADDR_NVM_CTRL;
    localparam logic [6:0] IFC = stn_pkg::ADDR_IF_CFG;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic i2c_mode = 1'b0;
    logic nvm_done = 1'b0;
    logic wdt_drv = 1'b0;
    logic wdt_lvl = 1'b1;
    logic sck, cs_n, mosi, pin, pin_o, pin_oe_n, sdo, sdo_oe_n, i2c_rst;
    logic ld_req, pg_req, st_x, st_y, st_z, st_sign, st_amp, tw;
    int bad_count = 0;
    int num_checks = 0;
    int ld_seen = 0;
    int pg_seen = 0;

    assign pin = !pin_oe_n ? pin_o : (wdt_drv ? wdt_lvl : mosi);

    stn_regs #(.WDT_SHORT_CYC(SHORT), .WDT_LONG_CYC(LONG)) u_dut (
        .clock_i(clock_i), .rst_i(rst_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
        .serial_data_in_pin_i(pin), .serial_data_in_pin_o(pin_o),
        .serial_data_in_pin_oe_n_o(pin_oe_n), .spi_sdo_o(sdo), .spi_sdo_oe_n_o(sdo_oe_n),
        .i2c_mode_i(i2c_mode), .i2c_if_reset_o(i2c_rst), .nvm_done_i(nvm_done),
        .nvm_load_req_o(ld_req), .nvm_prog_req_o(pg_req), .self_test_x_o(st_x),
        .self_test_y_o(st_y), .self_test_z_o(st_z), .self_test_sign_o(st_sign),
        .self_test_amp_o(st_amp), .three_wire_select_o(tw));

    // an undriven sdo shows the inverse of its last level, so a missing enable is caught
    stn_host_model u_host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi),
        .sdo_i(!sdo_oe_n ? sdo : ~sdo),
        .pin_i(pin), .three_wire_i(tw));

    initial
    begin
        forever #5 clock_i = ~clock_i;
    end

    always @(posedge clock_i)
    begin
        ld_seen += ld_req;
        pg_seen += pg_req;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        u_host.xfer(1'b1, a, 8'h00, d);
        chk(d, exp, what);
    endtask : rdchk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        u_host.xfer(1'b0, a, d, unused);
    endtask : wr

    task automatic pulse_done();
        @(posedge clock_i);
        #1 nvm_done = 1'b1;
        @(posedge clock_i);
        #1 nvm_done = 1'b0;
    endtask : pulse_done

    task automatic t_self_test();
        logic [7:0] vals [5] = '{8'h01, 8'h06, 8'h13, 8'hFF, 8'h00};
        logic [7:0] e;
        // host reads only this config, never acceleration data
        foreach (vals[i])
        begin
            e = vals[i] & 8'h17;
            wr(stn_pkg::ADDR_SELF_TEST, vals[i]);
            rdchk(stn_pkg::ADDR_SELF_TEST, e, "self-test readback");
            chk({st_x, st_y, st_z}, {e[1:0] == 2'h1, e[1:0] == 2'h2, e[1:0] == 2'h3}, "axis");
            chk({st_sign, st_amp}, {e[2], e[4]}, "sign amp");
        end
    endtask : t_self_test

    task automatic t_nvm();
        int p0;
        p0 = pg_seen;
        wr(NVM, 8'h02);
        rdchk(NVM, {stn_pkg::NVM_REMAIN_RESET, 4'h4}, "locked trigger");
        chk(8'(pg_seen - p0), 8'h00, "locked pulse");
        wr(NVM, 8'h01);
        for (int n = 15; n >= 0; n--)
        begin
            rdchk(NVM, {n[3:0], 4'h5}, "ready before trigger");
            p0 = pg_seen;
            wr(NVM, 8'h03);
            rdchk(NVM, (n > 0) ? {n[3:0] - 4'h1, 4'h1} : 8'h05, "after trigger");
            if (n == 15)
                wr(NVM, 8'h03);
            chk(8'(pg_seen - p0), (n > 0) ? 8'h01 : 8'h00, "program pulses");
            if (n > 0)
                pulse_done();
        end
        p0 = ld_seen;
        wr(NVM, 8'h01);
        rdchk(NVM, 8'h05, "ready before load");
        wr(NVM, 8'h09);
        rdchk(NVM, 8'h09, "load busy");
        chk(8'(ld_seen - p0), 8'h01, "load pulses");
        pulse_done();
        rdchk(NVM, 8'h05, "load done");
    endtask : t_nvm

    task automatic t_iface();
        rdchk(IFC, stn_pkg::IF_RESET, "interface reset");
        rdchk(7'h35, 8'h00, "unmapped");
        wr(IFC, 8'hFF);
        chk({7'h0, tw}, 8'h01, "three-wire select");
        rdchk(IFC, 8'h07, "three-wire readback");
        wr(IFC, 8'h00);
        rdchk(IFC, 8'h00, "four-wire readback");
    endtask : t_iface

    // lim 0 means no reset may come in 120 cycles
    task automatic wdt_case(input logic [7:0] cfg, input logic mode, input int lim);
        int k;
        wr(IFC, cfg);
        @(posedge clock_i);
        #1 wdt_drv = 1'b1;
        i2c_mode = mode;
        repeat (4) @(posedge clock_i);
        #1 wdt_lvl = 1'b0;
        k = 0;
        while (i2c_rst !== 1'b1 && k < 120)
        begin
            @(posedge clock_i);
            #1 k++;
        end
        chk({7'h0, lim == 0 ? k == 120 : k >= lim && k <= lim + 4}, 8'h01, "watchdog");
        wdt_lvl = 1'b1;
        repeat (4) @(posedge clock_i);
        #1 i2c_mode = 1'b0;
        wdt_drv = 1'b0;
    endtask : wdt_case

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        #500us;
        bad_count++;
        wrap_up();
    end

    initial
    begin
        repeat (20) @(posedge clock_i);
        #1 rst_i = 1'b0;
        repeat (5) @(posedge clock_i);
        chk({pin_oe_n, sdo_oe_n, i2c_rst, ld_req, pg_req, tw, st_x, st_y}, 8'hC0, "idle outputs");
        rdchk(stn_pkg::ADDR_SELF_TEST, stn_pkg::ST_RESET, "self-test reset");
        t_self_test();
        t_nvm();
        t_iface();
        wdt_case(8'h04, 1'b1, SHORT);
        wdt_case(8'h06, 1'b1, LONG);
        wdt_case(8'h00, 1'b1, 0);
        wdt_case(8'h04, 1'b0, 0);
        wrap_up();
    end
endmodule : selftest_nvm_iface_regs_bench
